// File: logic/sps_pkg.sv
// Constants, register map and carrier types of the servo position supervisor.
package sps_pkg;
    localparam logic [4:0] ADDR_RESOLUTION = 5'h00;
    localparam logic [4:0] ADDR_DIRECTION = 5'h01;
    localparam logic [4:0] ADDR_INPOS_RANGE = 5'h02;
    localparam logic [4:0] ADDR_OVERRIDE = 5'h03;
    localparam logic [4:0] ADDR_LIMIT_MODE = 5'h04;
    localparam logic [4:0] ADDR_LIMIT_POS = 5'h05;
    localparam logic [4:0] ADDR_LIMIT_NEG = 5'h06;
    localparam logic [4:0] ADDR_LIMIT_UNIT = 5'h07;
    localparam logic [4:0] ADDR_RETURN_THR = 5'h08;
    localparam logic [4:0] ADDR_OPEN_DELAY = 5'h09;
    localparam logic [4:0] ADDR_SINGLE_TURN = 5'h0A;
    localparam logic [4:0] ADDR_ORIGIN_REQ = 5'h0B;
    localparam logic [4:0] ADDR_OVERFLOW_THR = 5'h0C;
    localparam logic [4:0] ADDR_ORIGIN_SRC = 5'h0D;
    localparam logic [4:0] ADDR_TARGET = 5'h10;
    localparam logic [4:0] ADDR_SPEED = 5'h11;
    localparam logic [4:0] ADDR_COMMAND = 5'h12;
    localparam logic [4:0] ADDR_STATUS = 5'h13;
    localparam logic [4:0] ADDR_WARNING = 5'h14;
    localparam logic [4:0] ADDR_POSITION = 5'h15;
    localparam logic [4:0] ADDR_OPER_SPEED = 5'h16;
    localparam logic [4:0] ADDR_RESOLUTION_PPR = 5'h17;
    localparam logic [31:0] CONT_TARGET = 32'h3B9ACA00;
    localparam int ST_OVERFLOW = 0;
    localparam int ST_INPOS = 3;
    localparam int ST_SERVO_OFF = 4;
    localparam int ST_WARNING = 8;
    localparam int ST_ABS_ALARM = 12;
    localparam int WARN_LIMIT = 1;
    localparam int WARN_EXEC = 5;
    localparam int CMD_MOVE = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_ORIGIN = 2;
    localparam int CMD_ALARM_RESET = 3;
    localparam int CMD_SERVO_ON = 4;
    localparam logic [7:0] RST_OVERRIDE = 8'h64;
    localparam logic [31:0] RST_INPOS = 32'h00000005;
    localparam logic [15:0] RST_OVERFLOW_THR = 16'h0032;
    localparam logic [6:0] RST_RETURN_THR = 7'h0A;
    localparam logic [15:0] RST_OPEN_DELAY = 16'h01F4;
    localparam int MS_NS = 1000000;
    localparam int CLOCK_NS = 25;
    localparam int MS_CYCLES = MS_NS / CLOCK_NS;
    localparam logic [39:0] PULSES_PER_KILO = 40'h00000003E8;

    typedef struct packed {
        logic [4:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } sps_bus_type;

    typedef enum logic [3:0] {
        MOT_IDLE = 4'b0001,
        MOT_MOVE = 4'b0010,
        MOT_OPEN = 4'b0100,
        MOT_OFF = 4'b1000
    } sps_state_type;

    function automatic logic [15:0] sps_ppr(input logic [3:0] code);
        case (code)
            4'h0: return 16'h012C;
            4'h1: return 16'h0258;
            4'h2: return 16'h03E8;
            4'h3: return 16'h04B0;
            4'h4: return 16'h07D0;
            4'h5: return 16'h0BB8;
            4'h6: return 16'h1388;
            4'h7: return 16'h1770;
            4'h8: return 16'h2710;
            default: return 16'h2EE0;
        endcase
    endfunction : sps_ppr
endpackage : sps_pkg

// File: logic/sps_supervisor.sv
// Position supervisor: parameters, motion command checks and status reporting.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module sps_supervisor
    import sps_pkg::*;
#(
    parameter int MsCycles = MS_CYCLES
)(
    input wire logic clock,
    input wire logic resetn,
    input wire sps_bus_type bus,
    output logic [31:0] rdata,
    input wire logic signed [31:0] encoderPos,
    input wire logic signed [31:0] powerUpPos,
    input wire logic powerUpLoad,
    input wire logic singleTurnSaved,
    input wire logic originDone,
    output logic servoOn,
    output logic closedLoop,
    output logic moving,
    output logic continuousMotion,
    output logic driveCw,
    output logic signed [31:0] driveTarget,
    output logic signed [31:0] driveSpeed,
    output logic originRun,
    output logic inPosition
);
    initial
    begin
        if (MsCycles < 1)
        begin
            $error("MsCycles must be at least one");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [3:0] resolutionCode_r;
    logic positiveDirection_r;
    logic [31:0] inposRange_r;
    logic [7:0] overridePercent_r;
    logic [1:0] limitMode_r;
    logic signed [31:0] limitPos_r;
    logic signed [31:0] limitNeg_r;
    logic [1:0] limitUnit_r;
    logic [6:0] returnThr_r;
    logic [15:0] openDelay_r;
    logic singleTurn_r;
    logic originRequired_r;
    logic [15:0] overflowThr_r;
    logic [1:0] originSrc_r;
    logic signed [31:0] targetSet_r;
    logic signed [31:0] speedSet_r;
    logic signed [31:0] target_r;
    logic signed [31:0] operSpeed_r;
    logic [12:0] status_r;
    logic [7:0] warning_r;
    logic originValid_r;
    logic absAlarm_r;
    logic signed [31:0] position_r;
    logic [31:0] msCount_r;
    logic [15:0] idleMs_r;
    sps_state_type state_r;

    wire logic cmdWrite = bus.wr && bus.addr == ADDR_COMMAND;
    wire logic cmdMove = cmdWrite && bus.wdata[CMD_MOVE];
    wire logic cmdStop = cmdWrite && bus.wdata[CMD_STOP];
    wire logic cmdOrigin = cmdWrite && bus.wdata[CMD_ORIGIN];
    wire logic cmdReset = cmdWrite && bus.wdata[CMD_ALARM_RESET];
    wire logic cmdServo = cmdWrite && bus.wdata[CMD_SERVO_ON];

    ////////////////////////////////////////////////////////////////////////////
    // Range checks run in 40 bits so scaled limits and full positions never wrap.
    logic signed [39:0] limitScale;
    logic signed [39:0] limitHi;
    logic signed [39:0] limitLo;
    logic signed [39:0] resMax;
    logic signed [39:0] reqTarget;
    logic signed [39:0] deviation;
    logic [39:0] absDev;
    logic isCont;
    logic outOfLimit;
    logic signed [39:0] clampedTarget;
    logic signed [47:0] speedProduct;

    always_comb
    begin
        case (limitUnit_r)
            2'h0: limitScale = 40'sd100;
            2'h1: limitScale = 40'sd10;
            default: limitScale = 40'sd1;
        endcase
        limitHi = 40'(limitPos_r) * limitScale;
        limitLo = 40'(limitNeg_r) * limitScale;
        // Full-scale figure per code is 2^32 times pulses per rotation over 100000.
        resMax = 40'((64'h0000000100000000 * 64'(sps_ppr(resolutionCode_r)))
            / 64'd100000);
        isCont = targetSet_r == CONT_TARGET;
        reqTarget = positiveDirection_r ? -40'(targetSet_r) : 40'(targetSet_r);
        if (reqTarget > resMax)
        begin
            reqTarget = resMax;
        end
        else if (reqTarget < -resMax)
        begin
            reqTarget = -resMax;
        end
        outOfLimit = !isCont && limitMode_r != 2'h0
            && (reqTarget > limitHi || reqTarget < limitLo);
        clampedTarget = reqTarget > limitHi ? limitHi : (reqTarget < limitLo ? limitLo : reqTarget);
        deviation = 40'(target_r) - 40'(position_r);
        absDev = deviation < 0 ? 40'(-deviation) : 40'(deviation);
        speedProduct = 48'(speedSet_r) * 48'($signed({1'b0, overridePercent_r}));
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            resolutionCode_r <= 4'h2;
            positiveDirection_r <= 1'b0;
            inposRange_r <= RST_INPOS;
            overridePercent_r <= RST_OVERRIDE;
            limitMode_r <= 2'h0;
            limitPos_r <= 32'h0;
            limitNeg_r <= 32'h0;
            limitUnit_r <= 2'h0;
            returnThr_r <= RST_RETURN_THR;
            openDelay_r <= RST_OPEN_DELAY;
            singleTurn_r <= 1'b0;
            originRequired_r <= 1'b0;
            overflowThr_r <= RST_OVERFLOW_THR;
            originSrc_r <= 2'h0;
            targetSet_r <= 32'h0;
            speedSet_r <= 32'h0;
        end
        else if (bus.wr)
        begin
            case (bus.addr)
                ADDR_RESOLUTION: resolutionCode_r <= bus.wdata[3:0] > 4'h9 ? 4'h9 : bus.wdata[3:0];
                ADDR_DIRECTION: positiveDirection_r <= bus.wdata[0];
                ADDR_INPOS_RANGE: inposRange_r <= bus.wdata;
                ADDR_OVERRIDE: overridePercent_r <= bus.wdata[7:0];
                ADDR_LIMIT_MODE: limitMode_r <= bus.wdata[1:0];
                ADDR_LIMIT_POS: limitPos_r <= bus.wdata;
                ADDR_LIMIT_NEG: limitNeg_r <= bus.wdata;
                ADDR_LIMIT_UNIT: limitUnit_r <= bus.wdata[1:0];
                ADDR_RETURN_THR: returnThr_r <= bus.wdata[6:0] > 7'h48 ? 7'h48 : bus.wdata[6:0];
                ADDR_OPEN_DELAY: openDelay_r <= bus.wdata[15:0];
                ADDR_SINGLE_TURN: singleTurn_r <= bus.wdata[0];
                ADDR_ORIGIN_REQ: originRequired_r <= bus.wdata[0];
                ADDR_OVERFLOW_THR: overflowThr_r <= bus.wdata[14:0] == 15'h0 ? 16'h1
                    : {1'b0, bus.wdata[14:0]};
                ADDR_ORIGIN_SRC: originSrc_r <= bus.wdata[1:0];
                ADDR_TARGET: targetSet_r <= bus.wdata;
                ADDR_SPEED: speedSet_r <= bus.wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Origin bookkeeping: a change of origin source forgets the stored origin.
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            originValid_r <= 1'b0;
        end
        else if (bus.wr && bus.addr == ADDR_ORIGIN_SRC && bus.wdata[1:0] != originSrc_r)
        begin
            originValid_r <= 1'b0;
        end
        else if (originDone)
        begin
            originValid_r <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            absAlarm_r <= 1'b0;
        end
        else if (powerUpLoad && singleTurn_r && !singleTurnSaved)
        begin
            absAlarm_r <= 1'b1;
        end
        else if (cmdReset)
        begin
            absAlarm_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic signed [31:0] half;
    logic signed [31:0] folded;

    always_comb
    begin
        half = 32'(sps_ppr(resolutionCode_r) >> 1);
        folded = powerUpPos % $signed(32'(sps_ppr(resolutionCode_r)));
        if (folded > half)
        begin
            folded = folded - 32'(sps_ppr(resolutionCode_r));
        end
        else if (folded < -half)
        begin
            folded = folded + 32'(sps_ppr(resolutionCode_r));
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            position_r <= 32'h0;
        end
        else if (powerUpLoad)
        begin
            position_r <= singleTurn_r ? folded : powerUpPos;
        end
        else
        begin
            position_r <= encoderPos;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic refuseOrigin;
    logic acceptMove;
    logic overflow;

    // A move that loses to a stop or to the overflow trip in the same cycle is not accepted.
    always_comb
    begin
        refuseOrigin = originRequired_r && !originValid_r;
        overflow = !continuousMotion && absDev > 40'(overflowThr_r) * PULSES_PER_KILO;
        acceptMove = cmdMove && servoOn && !cmdStop && !overflow && !refuseOrigin
            && !(outOfLimit && limitMode_r == 2'h1);
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= MOT_OFF;
            target_r <= 32'h0;
            operSpeed_r <= 32'h0;
            continuousMotion <= 1'b0;
            driveCw <= 1'b1;
        end
        else
        begin
            case (state_r)
                MOT_IDLE, MOT_MOVE, MOT_OPEN:
                begin
                    if (overflow)
                    begin
                        state_r <= MOT_OFF;
                    end
                    else if (cmdStop)
                    begin
                        target_r <= position_r;
                        continuousMotion <= 1'b0;
                        state_r <= MOT_IDLE;
                    end
                    else if (acceptMove)
                    begin
                        // Parameters are sampled only here, so a running move keeps its own.
                        target_r <= isCont ? target_r
                            : 32'(limitMode_r == 2'h2 ? clampedTarget : reqTarget);
                        operSpeed_r <= 32'(speedProduct / 48'sd100);
                        continuousMotion <= isCont;
                        driveCw <= isCont ? speedSet_r >= 0 : reqTarget >= 40'(position_r);
                        state_r <= MOT_MOVE;
                    end
                    else if (state_r == MOT_MOVE && !continuousMotion && inPosition)
                    begin
                        state_r <= MOT_IDLE;
                    end
                    else if (state_r == MOT_IDLE && idleMs_r >= openDelay_r && msCount_r == 32'h0
                        && !cmdWrite)
                    begin
                        state_r <= MOT_OPEN;
                    end
                    else if (state_r == MOT_OPEN
                        && absDev * 40'd3600 > 40'(returnThr_r) * 40'(sps_ppr(resolutionCode_r)))
                    begin
                        state_r <= MOT_MOVE;
                    end
                end
                MOT_OFF:
                begin
                    if (cmdServo && !absAlarm_r)
                    begin
                        target_r <= position_r;
                        state_r <= MOT_IDLE;
                    end
                end
                default: state_r <= MOT_OFF;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            msCount_r <= 32'h0;
            idleMs_r <= 16'h0;
        end
        else if (state_r != MOT_IDLE || cmdWrite)
        begin
            msCount_r <= 32'h0;
            idleMs_r <= 16'h0;
        end
        else if (msCount_r == 32'(MsCycles - 1))
        begin
            msCount_r <= 32'h0;
            idleMs_r <= idleMs_r == 16'hFFFF ? idleMs_r : idleMs_r + 16'h1;
        end
        else
        begin
            msCount_r <= msCount_r + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Warnings are sticky until the alarm reset command; a new event wins over the reset.
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            status_r <= 13'h0;
            warning_r <= 8'h0;
        end
        else
        begin
            status_r[ST_INPOS] <= inPosition;
            status_r[ST_SERVO_OFF] <= state_r == MOT_OFF;
            status_r[ST_ABS_ALARM] <= absAlarm_r;
            if (state_r != MOT_OFF && overflow)
            begin
                status_r[ST_OVERFLOW] <= 1'b1;
            end
            else if (cmdReset)
            begin
                status_r[ST_OVERFLOW] <= 1'b0;
            end
            if (cmdMove && refuseOrigin)
            begin
                status_r[ST_WARNING] <= 1'b1;
                warning_r[WARN_EXEC] <= 1'b1;
            end
            else if (cmdMove && outOfLimit)
            begin
                status_r[ST_WARNING] <= 1'b1;
                if (limitMode_r == 2'h1)
                begin
                    warning_r[WARN_LIMIT] <= 1'b1;
                end
            end
            else if (cmdReset)
            begin
                status_r[ST_WARNING] <= 1'b0;
                warning_r <= 8'h0;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata <= 32'h0;
        end
        else if (bus.rd)
        begin
            case (bus.addr)
                ADDR_STATUS: rdata <= {19'h0, status_r};
                ADDR_WARNING: rdata <= {24'h0, warning_r};
                ADDR_POSITION: rdata <= position_r;
                ADDR_OPER_SPEED: rdata <= operSpeed_r;
                ADDR_RESOLUTION_PPR: rdata <= {16'h0, sps_ppr(resolutionCode_r)};
                ADDR_TARGET: rdata <= targetSet_r;
                ADDR_SPEED: rdata <= speedSet_r;
                ADDR_OVERRIDE: rdata <= {24'h0, overridePercent_r};
                ADDR_LIMIT_MODE: rdata <= {30'h0, limitMode_r};
                default: rdata <= 32'h0;
            endcase
        end
    end

    always_comb
    begin
        servoOn = state_r != MOT_OFF;
        closedLoop = state_r != MOT_OPEN;
        moving = state_r == MOT_MOVE;
        driveTarget = target_r;
        driveSpeed = continuousMotion ? (operSpeed_r < 0 ? -operSpeed_r : operSpeed_r) : operSpeed_r;
        originRun = cmdOrigin && servoOn;
        inPosition = servoOn && !continuousMotion && {8'h0, inposRange_r} >= absDev;
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_overflow;
        @(posedge clock) disable iff (!resetn)
        status_r[ST_OVERFLOW] && !$past(status_r[ST_OVERFLOW]) |-> state_r == MOT_OFF;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow without servo off");

    property p_stop;
        @(posedge clock) disable iff (!resetn)
        cmdStop && servoOn && !overflow |=> target_r == $past(position_r);
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not load position");

    property p_refuse;
        @(posedge clock) disable iff (!resetn)
        cmdMove && refuseOrigin |=> warning_r[WARN_EXEC] && status_r[ST_WARNING]
            && ($past(state_r) != MOT_IDLE || state_r != MOT_MOVE);
    endproperty
    a_refuse: assert property (p_refuse) else $error("origin gating failed");

    property p_limit;
        @(posedge clock) disable iff (!resetn)
        cmdMove && outOfLimit && limitMode_r == 2'h1 && !refuseOrigin |=> warning_r[WARN_LIMIT];
    endproperty
    a_limit: assert property (p_limit) else $error("limit warning missing");

    property p_inpos;
        @(posedge clock) disable iff (!resetn)
        inPosition |=> status_r[ST_INPOS];
    endproperty
    a_inpos: assert property (p_inpos) else $error("in-position status missing");

    property p_open;
        @(posedge clock) disable iff (!resetn)
        state_r == MOT_OPEN |-> idleMs_r >= openDelay_r || $past(state_r) == MOT_OPEN;
    endproperty
    a_open: assert property (p_open) else $error("open loop entered early");

    property p_abs;
        @(posedge clock) disable iff (!resetn)
        powerUpLoad && singleTurn_r && !singleTurnSaved |=> ##1 status_r[ST_ABS_ALARM];
    endproperty
    a_abs: assert property (p_abs) else $error("absolute alarm missing");

    property p_cont;
        @(posedge clock) disable iff (!resetn)
        acceptMove && isCont |=> continuousMotion && driveCw == ($past(speedSet_r) >= 0);
    endproperty
    a_cont: assert property (p_cont) else $error("continuous direction wrong");

    c_move: cover property (@(posedge clock) disable iff (!resetn)
        acceptMove ##[1:50] state_r == MOT_IDLE);
    c_open: cover property (@(posedge clock) disable iff (!resetn)
        state_r == MOT_OPEN ##1 state_r == MOT_MOVE);
    c_refuse: cover property (@(posedge clock) disable iff (!resetn) cmdMove && outOfLimit);
endmodule : sps_supervisor

// File: test/sps_host_model.sv
// Host side model that issues register bus cycles one strobe at a time.
`timescale 1ns/10ps
module sps_host_model
    import sps_pkg::*;
(
    input wire logic clock,
    output sps_bus_type bus,
    input wire logic [31:0] rdata
);
    initial bus = '0;

    // Write data is inverted once the strobe drops, so a late capture would be seen.
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge clock);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge clock);
        bus <= '{a, ~v, 1'b0, 1'b0};
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [31:0] v);
        @(posedge clock);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clock);
        bus <= '{a, 32'h0, 1'b0, 1'b0};
        @(posedge clock);
        v = rdata;
    endtask : rd
endmodule : sps_host_model

// File: test/sps_supervisor_tb_top.sv
// Self-checking bench of the servo position supervisor.
`timescale 1ns/10ps
module sps_supervisor_tb_top
    import sps_pkg::*;
();
    logic clock = 1'b0;
    logic resetn = 1'b0;
    sps_bus_type bus;
    logic [31:0] rdata;
    logic signed [31:0] encoderPos = 32'sh0;
    logic signed [31:0] powerUpPos = 32'sh0;
    logic powerUpLoad = 1'b0;
    logic singleTurnSaved = 1'b0;
    logic originDone = 1'b0;
    logic servoOn, closedLoop, moving, continuousMotion, driveCw, originRun, inPosition;
    logic signed [31:0] driveTarget, driveSpeed;
    logic [31:0] seed = 32'h8CCF;
    int mismatches = 0;
    int num_checks = 0;
    int pprTable[10] = '{300, 600, 1000, 1200, 2000, 3000, 5000, 6000, 10000, 12000};
    int unitScale[3] = '{100, 10, 1};

    always #12.5 clock = ~clock;

    // A short millisecond tick keeps the open-loop delay within a short run.
    sps_supervisor #(.MsCycles(4)) u_sps_supervisor (
        .clock(clock), .resetn(resetn), .bus(bus), .rdata(rdata),
        .encoderPos(encoderPos), .powerUpPos(powerUpPos), .powerUpLoad(powerUpLoad),
        .singleTurnSaved(singleTurnSaved), .originDone(originDone), .servoOn(servoOn),
        .closedLoop(closedLoop), .moving(moving), .continuousMotion(continuousMotion),
        .driveCw(driveCw), .driveTarget(driveTarget), .driveSpeed(driveSpeed),
        .originRun(originRun), .inPosition(inPosition));
    sps_host_model u_sps_host_model (.clock(clock), .bus(bus), .rdata(rdata));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("Checks %0d, mismatches %0d.", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic w(input logic [4:0] a, input logic [31:0] v);
        u_sps_host_model.wr(a, v);
        // One more edge, so that checks see what the strobe's edge launched.
        @(posedge clock);
    endtask : w

    task automatic rc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        u_sps_host_model.rd(a, d);
        check(d & m, e);
    endtask : rc

    task automatic enc(input int v);
        @(posedge clock);
        encoderPos <= v;
        repeat (2) @(posedge clock);
    endtask : enc

    task automatic pwr(input int p, input int e);
        @(posedge clock);
        powerUpPos <= p;
        powerUpLoad <= 1'b1;
        fork
            begin
                @(posedge clock);
                powerUpLoad <= 1'b0;
            end
        join_none
        rc(ADDR_POSITION, '1, 32'(e));
    endtask : pwr

    task automatic org();
        @(posedge clock);
        originDone <= 1'b1;
        @(posedge clock);
        originDone <= 1'b0;
    endtask : org

    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches++;
        test_done();
    end

    initial
    begin
        int spd;
        int ovr;
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        rc(ADDR_OVERRIDE, '1, 32'(RST_OVERRIDE));
        rc(5'h1F, '1, 32'h0);
        for (int i = 0; i < 10; i++)
        begin
            w(ADDR_RESOLUTION, 32'(i));
            rc(ADDR_RESOLUTION_PPR, '1, 32'(pprTable[i]));
        end
        w(ADDR_COMMAND, 32'h10);
        repeat (4)
        begin
            spd = int'(rnd() % 32'd5000);
            ovr = int'(rnd() % 32'd201);
            w(ADDR_COMMAND, 32'h2);
            w(ADDR_OVERRIDE, 32'(ovr));
            w(ADDR_SPEED, 32'(spd));
            w(ADDR_TARGET, 32'd100);
            w(ADDR_COMMAND, 32'h1);
            rc(ADDR_OPER_SPEED, '1, 32'(spd * ovr / 100));
            rc(ADDR_SPEED, '1, 32'(spd));
        end
        w(ADDR_OVERRIDE, 32'd100);
        check(driveSpeed, 32'(spd * ovr / 100));
        for (int k = -6; k <= 6; k++)
        begin
            enc(100 + k);
            check(inPosition, 1'(k >= -5 && k <= 5));
        end
        enc(100);
        rc(ADDR_STATUS, 32'h8, 32'h8);
        enc(40);
        w(ADDR_COMMAND, 32'h2);
        check(driveTarget, 32'd40);
        check(inPosition, 1'b1);
        w(ADDR_DIRECTION, 32'd1);
        w(ADDR_TARGET, 32'd200);
        w(ADDR_COMMAND, 32'h1);
        check(driveTarget, -32'sd200);
        w(ADDR_COMMAND, 32'h2);
        w(ADDR_LIMIT_MODE, 32'd1);
        w(ADDR_LIMIT_UNIT, 32'd2);
        w(ADDR_LIMIT_POS, 32'd1000);
        w(ADDR_LIMIT_NEG, -32'sd1000);
        w(ADDR_TARGET, 32'd2000);
        w(ADDR_COMMAND, 32'h1);
        check(moving, 1'b0);
        rc(ADDR_WARNING, '1, 32'h2);
        rc(ADDR_STATUS, 32'h100, 32'h100);
        w(ADDR_DIRECTION, 32'd0);
        w(ADDR_LIMIT_MODE, 32'd2);
        for (int u = 0; u < 3; u++)
        begin
            w(ADDR_LIMIT_UNIT, 32'(u));
            w(ADDR_LIMIT_POS, 32'd7);
            w(ADDR_TARGET, 32'd5000);
            w(ADDR_COMMAND, 32'h1);
            check(driveTarget, 32'(7 * unitScale[u]));
        end
        w(ADDR_COMMAND, 32'h8);
        w(ADDR_LIMIT_MODE, 32'd1);
        w(ADDR_DIRECTION, 32'd1);
        for (int s = -1; s <= 1; s += 2)
        begin
            w(ADDR_COMMAND, 32'h2);
            w(ADDR_SPEED, 32'(s * 300));
            w(ADDR_TARGET, CONT_TARGET);
            w(ADDR_COMMAND, 32'h1);
            check(continuousMotion, 1'b1);
            check(driveCw, 1'(s > 0));
        end
        rc(ADDR_WARNING, '1, 32'h0);
        w(ADDR_COMMAND, 32'h2);
        w(ADDR_LIMIT_MODE, 32'd0);
        w(ADDR_OVERFLOW_THR, 32'd1);
        enc(0);
        w(ADDR_TARGET, 32'd0);
        w(ADDR_COMMAND, 32'h1);
        enc(1000);
        check(servoOn, 1'b1);
        enc(1001);
        repeat (3) @(posedge clock);
        check(servoOn, 1'b0);
        rc(ADDR_STATUS, 32'h1, 32'h1);
        w(ADDR_RESOLUTION, 32'd2);
        w(ADDR_SINGLE_TURN, 32'd1);
        pwr(-1600, 400);
        pwr(600, -400);
        pwr(2300, 300);
        rc(ADDR_STATUS, 32'h1000, 32'h1000);
        w(ADDR_COMMAND, 32'h10);
        check(servoOn, 1'b0);
        w(ADDR_COMMAND, 32'h8);
        rc(ADDR_STATUS, 32'h1001, 32'h0);
        w(ADDR_COMMAND, 32'h10);
        check(servoOn, 1'b1);
        w(ADDR_DIRECTION, 32'd0);
        w(ADDR_OVERFLOW_THR, 32'd50);
        w(ADDR_ORIGIN_REQ, 32'd1);
        w(ADDR_TARGET, 32'd1100);
        w(ADDR_COMMAND, 32'h1);
        check(moving, 1'b0);
        rc(ADDR_STATUS, '1, 32'd264);
        rc(ADDR_WARNING, '1, 32'd32);
        org();
        w(ADDR_ORIGIN_SRC, 32'd1);
        w(ADDR_COMMAND, 32'h1);
        check(moving, 1'b0);
        org();
        w(ADDR_COMMAND, 32'h1);
        check(moving, 1'b1);
        check(driveTarget, 32'd1100);
        w(ADDR_OPEN_DELAY, 32'd2);
        enc(1100);
        repeat (12) @(posedge clock);
        check(closedLoop, 1'b0);
        enc(1102);
        @(posedge clock);
        check(closedLoop, 1'b0);
        enc(1103);
        @(posedge clock);
        check(closedLoop, 1'b1);
        check(driveTarget, 32'd1100);
        test_done();
    end
endmodule : sps_supervisor_tb_top
